// >>> hw/scgc_pkg.sv
// Constants for the sleep-mode clock gating control register
package scgc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          SCGC_ADDR_W     = 12;
  localparam logic [11:0] SCGC_GATE0_OFFS = 12'h110;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCGC_ADC_BIT  = 16;
  localparam int SCGC_RATE_MSB = 9;
  localparam int SCGC_RATE_LSB = 8;
  localparam int SCGC_HIB_BIT  = 6;
  localparam int SCGC_WDT_BIT  = 3;

  // ----------------------------------------------------------------
  // Reset value and writable bits
  // ----------------------------------------------------------------
  localparam logic [31:0] SCGC_GATE0_RESET = 32'h0000_0040;
  localparam logic [31:0] SCGC_GATE0_WMASK = 32'h0001_0348;

  // ----------------------------------------------------------------
  // Converter rate encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SCGC_RATE_125K = 2'h0;
  localparam logic [1:0] SCGC_RATE_250K = 2'h1;
endpackage

// >>> hw/scgc_top.sv
// Sleep-mode clock gating register 0 with APB slave and fault flags
`timescale 1ns/1ps
module scgc_top #(
  parameter int ADDR_W = scgc_pkg::SCGC_ADDR_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sleep_mode,
  input  wire logic              auto_clock_gating,
  input  wire logic [31:0]       run_clock_gate_0,
  input  wire logic              watchdog_access,
  input  wire logic              adc_access,
  output logic                   hibernate_clock_enable,
  output logic                   watchdog_clock_enable,
  output logic                   adc_clock_enable,
  output logic      [1:0]        converter_rate_select,
  output logic                   watchdog_fault,
  output logic                   adc_fault
);
  import scgc_pkg::*;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] gate_reg;
  logic [31:0] gate_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        hit;
  logic        setup;
  logic        done;

  assign hit   = (paddr == ADDR_W'(SCGC_GATE0_OFFS));
  assign setup = psel && !penable && !pready_reg;
  assign done  = psel && penable && pready_reg;

  always_comb begin
    gate_next    = gate_reg;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (setup) begin
      pready_next  = 1'b1;
      pslverr_next = !hit;
      prdata_next  = (hit && !pwrite) ? (gate_reg & SCGC_GATE0_WMASK) : 32'h0000_0000;
    end
    if (done && pwrite && hit && !pslverr_reg) begin
      gate_next = pwdata & SCGC_GATE0_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg    <= SCGC_GATE0_RESET;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      gate_reg    <= gate_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------
  // Clock enable selection
  // ----------------------------------------------------------------
  logic       apply_sleep;
  logic       hib_en_reg;
  logic       hib_en_next;
  logic       wdt_en_reg;
  logic       wdt_en_next;
  logic       adc_en_reg;
  logic       adc_en_next;
  logic [1:0] rate_reg;
  logic [1:0] rate_next;

  assign apply_sleep = sleep_mode && auto_clock_gating;

  always_comb begin
    if (apply_sleep) begin
      hib_en_next = gate_reg[SCGC_HIB_BIT];
      wdt_en_next = gate_reg[SCGC_WDT_BIT];
      adc_en_next = gate_reg[SCGC_ADC_BIT];
      rate_next   = gate_reg[SCGC_RATE_MSB:SCGC_RATE_LSB];
    end else begin
      hib_en_next = run_clock_gate_0[SCGC_HIB_BIT];
      wdt_en_next = run_clock_gate_0[SCGC_WDT_BIT];
      adc_en_next = run_clock_gate_0[SCGC_ADC_BIT];
      rate_next   = run_clock_gate_0[SCGC_RATE_MSB:SCGC_RATE_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hib_en_reg <= SCGC_GATE0_RESET[SCGC_HIB_BIT];
      wdt_en_reg <= SCGC_GATE0_RESET[SCGC_WDT_BIT];
      adc_en_reg <= SCGC_GATE0_RESET[SCGC_ADC_BIT];
      rate_reg   <= SCGC_RATE_125K;
    end else begin
      hib_en_reg <= hib_en_next;
      wdt_en_reg <= wdt_en_next;
      adc_en_reg <= adc_en_next;
      rate_reg   <= rate_next;
    end
  end

  assign hibernate_clock_enable = hib_en_reg;
  assign watchdog_clock_enable  = wdt_en_reg;
  assign adc_clock_enable       = adc_en_reg;
  assign converter_rate_select  = rate_reg;

  // ----------------------------------------------------------------
  // Bus fault flags for gated-off units
  // ----------------------------------------------------------------
  logic wdt_fault_reg;
  logic wdt_fault_next;
  logic adc_fault_reg;
  logic adc_fault_next;

  always_comb begin
    wdt_fault_next = watchdog_access && !wdt_en_reg;
    adc_fault_next = adc_access && !adc_en_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_fault_reg <= 1'b0;
      adc_fault_reg <= 1'b0;
    end else begin
      wdt_fault_reg <= wdt_fault_next;
      adc_fault_reg <= adc_fault_next;
    end
  end

  assign watchdog_fault = wdt_fault_reg;
  assign adc_fault      = adc_fault_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic boot_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  sequence setup_s;
    psel && !penable && !pready_reg;
  endsequence

  sequence answer_s;
    pready ##1 !pready;
  endsequence

  sequence write_done_s;
    psel && penable && pready && pwrite && !pslverr && hit;
  endsequence

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_s |=> answer_s)
    else $error("APB answer not one access cycle");

  reset_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    boot_reg |-> (gate_reg == SCGC_GATE0_RESET) && hibernate_clock_enable && !watchdog_clock_enable)
    else $error("Register reset value wrong");

  hib_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    apply_sleep && $stable(gate_reg) |=> hibernate_clock_enable == $past(gate_reg[SCGC_HIB_BIT]))
    else $error("Hibernate enable not from bit 6");

  wdt_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    write_done_s ##1 apply_sleep |=> watchdog_clock_enable == $past(pwdata[3], 2))
    else $error("Watchdog enable not written");

  wdt_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_access && !watchdog_clock_enable |=> watchdog_fault
      ##1 (watchdog_fault == ($past(watchdog_access) && !$past(watchdog_clock_enable))))
    else $error("Watchdog fault missing");

  wdt_nofault_a: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_clock_enable |=> !watchdog_fault)
    else $error("Watchdog fault while clocked");

  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> (prdata & 32'hfffe_fcb7) == 32'h0000_0000 && (gate_reg & 32'hfffe_fcb7) == 32'h0000_0000)
    else $error("Reserved bits not zero");

  adc_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    adc_access && !adc_clock_enable |=> adc_fault)
    else $error("Converter fault missing");

  rate_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    write_done_s ##1 apply_sleep |=> converter_rate_select == $past(pwdata[9:8], 2))
    else $error("Rate field not applied");

  run_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    !apply_sleep |=> watchdog_clock_enable == $past(run_clock_gate_0[3])
      && adc_clock_enable == $past(run_clock_gate_0[16]))
    else $error("Run gating not applied outside Sleep");

endmodule

// >>> dv/tb.sv
// Self-checking testbench for the sleep-mode clock gating register
`timescale 1ns/1ps
module tb;
  import scgc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_mode = 1'b1;
  logic        auto_clock_gating = 1'b1;
  logic [31:0] run_clock_gate_0 = 32'h0001_0308;
  logic        watchdog_access = 1'b0;
  logic        adc_access = 1'b0;
  logic        hib_en;
  logic        wdt_en;
  logic        adc_en;
  logic [1:0]  rate;
  logic        wdt_flt;
  logic        adc_flt;
  logic [31:0] rd;
  logic        er;
  int          fail_count = 0;
  int          check_count = 0;

  always #12.5 pclk = ~pclk;

  scgc_top i_dut (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .sleep_mode             (sleep_mode),
    .auto_clock_gating      (auto_clock_gating),
    .run_clock_gate_0       (run_clock_gate_0),
    .watchdog_access        (watchdog_access),
    .adc_access             (adc_access),
    .hibernate_clock_enable (hib_en),
    .watchdog_clock_enable  (wdt_en),
    .adc_clock_enable       (adc_en),
    .converter_rate_select  (rate),
    .watchdog_fault         (wdt_flt),
    .adc_fault              (adc_flt)
  );

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic en_chk(input logic [4:0] e);
    repeat (2) @(negedge pclk);
    chk("enables", {27'h0, e}, {27'h0, hib_en, wdt_en, adc_en, rate});
  endtask

  task automatic flt(input logic w, input logic [1:0] e);
    @(posedge pclk);
    watchdog_access <= w;
    adc_access      <= ~w;
    @(posedge pclk);
    watchdog_access <= 1'b0;
    adc_access      <= 1'b0;
    @(negedge pclk);
    chk("faults", {30'h0, e}, {30'h0, wdt_flt, adc_flt});
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h110, 32'h0);
    chk("reset value", SCGC_GATE0_RESET, rd);
    en_chk(5'b10000);
    flt(1'b1, 2'b10);
    flt(1'b0, 2'b01);
    apb(1'b1, 12'h110, 32'hffff_fdff);
    apb(1'b0, 12'h110, 32'h0);
    chk("masked read", 32'h0001_0148, rd);
    en_chk(5'b11101);
    flt(1'b1, 2'b00);
    flt(1'b0, 2'b00);
    apb(1'b1, 12'h110, 32'h0000_0100);
    en_chk(5'b00001);
    apb(1'b1, 12'h110, 32'h0000_0040);
    en_chk(5'b10000);
    @(posedge pclk);
    auto_clock_gating <= 1'b0;
    en_chk(5'b01111);
    @(posedge pclk);
    auto_clock_gating <= 1'b1;
    sleep_mode        <= 1'b0;
    en_chk(5'b01111);
    @(posedge pclk);
    sleep_mode <= 1'b1;
    en_chk(5'b10000);
    apb(1'b0, 12'h114, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h114, 32'hffff_ffff);
    apb(1'b0, 12'h110, 32'h0);
    chk("after unmapped write", 32'h0000_0040, rd);
    stop_test();
  end

  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule
